// *** rtl/lcdc_map.svh ***
`ifndef LCDC_MAP_SVH
`define LCDC_MAP_SVH
// ---------------------------------------------------------------
// register indices (byte address is index times four)
// ---------------------------------------------------------------
`define LCDC_IDX_CLK      4'h0
`define LCDC_IDX_CTL      4'h1
`define LCDC_IDX_TIM1     4'h2
`define LCDC_IDX_TIM2     4'h3
`define LCDC_IDX_PWR      4'h4
`define LCDC_IDX_DSP      4'h5
`define LCDC_IDX_INTF     4'h6
`define LCDC_IDX_INTE     4'h7
// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define LCDC_CLK_DEBUG_RUN    8
`define LCDC_CLK_DIV_LSB  4
`define LCDC_CLK_SRC_LSB  0
`define LCDC_CTL_DIS      1
`define LCDC_CTL_EN       0
`define LCDC_TIM1_FRM_LSB 8
`define LCDC_TIM1_DTY_LSB 0
`define LCDC_TIM2_BST_LSB 8
`define LCDC_TIM2_NL_LSB  0
`define LCDC_PWR_EXT      15
`define LCDC_PWR_LC_LSB   8
`define LCDC_PWR_BST      4
`define LCDC_PWR_HEAVY_LOAD_MODE     2
`define LCDC_PWR_VSEL     1
`define LCDC_PWR_VEN      0
// ---------------------------------------------------------------
// reset values and divider code limits
// ---------------------------------------------------------------
`define LCDC_RST_DEBUG_RUN    1'b1
`define LCDC_RST_FRM      4'h7
`define LCDC_RST_DUTY     2'h3
`define LCDC_RST_BSTC     2'h1
`define LCDC_RST_EXT      1'b1
`define LCDC_DIV_BYPASS   3'h7
`define LCDC_DIV_MAXCODE  3'h5
`endif

// *** rtl/lcdc_pkg.sv ***
package lcdc_pkg;
  typedef enum logic [1:0] {
    LCDC_SRC_INTERNAL_OSCILLATOR = 2'b00,
    LCDC_SRC_LOW  = 2'b01,
    LCDC_SRC_HIGH = 2'b10,
    LCDC_SRC_EXT  = 2'b11
  } lcdc_src_t;
  typedef enum logic [1:0] {
    LCDC_ST_OFF = 2'b00,
    LCDC_ST_RUN = 2'b01
  } lcdc_state_t;
endpackage : lcdc_pkg

// *** rtl/lcdc_clkdiv.sv ***
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// power-of-two divider producing one-cycle enable pulses
// ---------------------------------------------------------------
module lcdc_clkdiv #(
  parameter int W = 7
) (
  // clock and reset
  input  wire logic         core_clk_i,
  input  wire logic         rstn_i,
  // control
  input  wire logic         run_i,
  input  wire logic         tick_i,
  input  wire logic [2:0]   shift_i,
  // enable out
  output logic              pulse_o
);
  logic [W-1:0] cnt;
  logic [W-1:0] mask;

  // mask selects low bits; all ones means period of 2**shift ticks
  assign mask = W'((8'h01 << shift_i) - 8'h01);

  // counter only advances on input ticks
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i || !run_i) begin
      cnt     <= '0;
      pulse_o <= 1'b0;
    end else begin
      pulse_o <= 1'b0;
      if (tick_i) begin
        if ((cnt & mask) == mask) begin
          cnt     <= '0;
          pulse_o <= 1'b1;
        end else begin
          cnt <= cnt + W'(1);
        end
      end
    end
  end
endmodule : lcdc_clkdiv
`default_nettype wire

// *** rtl/lcdc_regs.sv ***
// Contract
// [R01] frame flag sets each frame switch, write-1 clears, irq when flag and enable
// [R02] debug_run bit 8 keeps clock running in debug; resets to one
// [R03] clock_source codes 0..3 pick internal, low, high, external clocks
// [R04] internal/high divide 4..128 for codes 0..5; low/external only code 7
// [R05] sources missing on this chip cannot be selected
// [R06] clock_select writes only take effect while module_enable is zero
// [R07] display off: discharge one drives pins low, zero floats them
// [R08] module_enable one enables driver and starts operating clock
// [R09] enable falling while displaying forces display off and regulator off
// [R10] frame_rate_select bits 11-8 of frame_timing, reset seven
// [R11] drive_duty low two bits of frame_timing, reset three
// [R12] booster clock is operating clock over 4,16,32,64; reset code one
// [R13] inverse_line_count bits 1-0 of booster_line_timing, zero is off
// [R14] supply_mode_select bit 15 external when one; resets to one
// [R15] contrast_level steps lightest at zero to darkest at fifteen
// [R16] booster_on bit 4 switches voltage booster
// [R17] heavy_load_mode bit 2 selects regulator heavy load protection
// [R18] regulator_output_select chooses second or first reference level
// [R19] software keeps regulator_output_select zero in external supply mode
// [R20] regulator_on bit 0 switches the voltage regulator
// [R21] writing one to supply_mode_select clears regulator_on
// [R22] frame_irq_enable, reset zero, gates frame flag onto the request
// [R23] reserved bits read zero and ignore writes
`timescale 1ns/1ps
`default_nettype none
`include "lcdc_map.svh"
module lcdc_regs #(
  parameter logic [3:0] SRC_AVAIL = 4'b1111,
  parameter int         FRM_BASE  = 64
) (
  // clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        rstn_i,
  // register port
  input  wire logic [3:0]  addr_i,
  input  wire logic [15:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic [15:0]      rdata_o,
  // clock sources (enables on core clock)
  input  wire logic [3:0]  src_tick_i,
  input  wire logic        debug_i,
  // panel control
  output logic             op_clk_en_o,
  output logic             boost_clk_en_o,
  output logic             pin_low_o,
  output logic             pin_hiz_o,
  output logic [3:0]       frame_rate_o,
  output logic [1:0]       duty_o,
  output logic [1:0]       inv_lines_o,
  output logic [1:0]       display_ctl_o,
  // power supply
  output logic             ext_supply_o,
  output logic [3:0]       contrast_o,
  output logic             booster_on_o,
  output logic             heavy_load_o,
  output logic             reg_out_sel_o,
  output logic             reg_on_o,
  // interrupt request
  output logic             irq_o
);
  // ---------------------------------------------------------------
  // register state
  // ---------------------------------------------------------------
  logic       debug_run;
  logic [2:0] clock_divider;
  logic [1:0] clock_source;
  logic       module_enable;
  logic       pin_discharge_enable;
  logic [3:0] frame_rate_select;
  logic [1:0] drive_duty;
  logic [1:0] booster_clock_select;
  logic [1:0] inverse_line_count;
  logic       supply_mode_select;
  logic [3:0] contrast_level;
  logic       booster_on;
  logic       heavy_load_mode;
  logic       regulator_output_select;
  logic       regulator_on;
  logic [1:0] display_control;
  logic [2:0] display_extra;
  logic       frame_flag;
  logic       frame_irq_enable;
  lcdc_pkg::lcdc_state_t state;
  lcdc_pkg::lcdc_state_t next_state;

  // write strobes per register
  function automatic logic hit(input logic [3:0] a, input logic [3:0] idx);
    hit = (a == idx);
  endfunction : hit

  logic wr_clk, wr_ctl, wr_tim1, wr_tim2, wr_pwr, wr_dsp, wr_intf, wr_inte;
  assign wr_clk  = wr_i && hit(addr_i, `LCDC_IDX_CLK);
  assign wr_ctl  = wr_i && hit(addr_i, `LCDC_IDX_CTL);
  assign wr_tim1 = wr_i && hit(addr_i, `LCDC_IDX_TIM1);
  assign wr_tim2 = wr_i && hit(addr_i, `LCDC_IDX_TIM2);
  assign wr_pwr  = wr_i && hit(addr_i, `LCDC_IDX_PWR);
  assign wr_dsp  = wr_i && hit(addr_i, `LCDC_IDX_DSP);
  assign wr_intf = wr_i && hit(addr_i, `LCDC_IDX_INTF);
  assign wr_inte = wr_i && hit(addr_i, `LCDC_IDX_INTE);

  // ---------------------------------------------------------------
  // clock selection
  // ---------------------------------------------------------------
  // a source missing on this chip leaves the old selection in place
  logic       src_ok;
  logic [2:0] wr_div;
  logic [1:0] wr_src;
  assign wr_src = wdata_i[`LCDC_CLK_SRC_LSB +: 2];
  assign wr_div = wdata_i[`LCDC_CLK_DIV_LSB +: 3];
  assign src_ok = SRC_AVAIL[wr_src]; // [R05]

  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      debug_run     <= `LCDC_RST_DEBUG_RUN; // [R02]
      clock_divider <= 3'h0;
      clock_source  <= 2'h0;
    end else if (wr_clk && !module_enable) begin // [R06]
      debug_run     <= wdata_i[`LCDC_CLK_DEBUG_RUN];
      clock_divider <= wr_div;
      if (src_ok) begin
        clock_source <= wr_src; // [R03]
      end
    end
  end

  // ---------------------------------------------------------------
  // module control and shutdown sequencing
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      module_enable        <= 1'b0;
      pin_discharge_enable <= 1'b0;
    end else if (wr_ctl) begin
      module_enable        <= wdata_i[`LCDC_CTL_EN]; // [R08]
      pin_discharge_enable <= wdata_i[`LCDC_CTL_DIS];
    end
  end

  // tracks whether the panel is being driven
  always_comb begin
    next_state = state;
    case (state)
      lcdc_pkg::LCDC_ST_OFF: begin
        if (module_enable && display_control != 2'h0) begin
          next_state = lcdc_pkg::LCDC_ST_RUN;
        end
      end
      lcdc_pkg::LCDC_ST_RUN: begin
        if (!module_enable || display_control == 2'h0) begin
          next_state = lcdc_pkg::LCDC_ST_OFF;
        end
      end
      default: next_state = lcdc_pkg::LCDC_ST_OFF;
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      state <= lcdc_pkg::LCDC_ST_OFF;
    end else begin
      state <= next_state;
    end
  end

  // enable dropped while displaying; acts the cycle after the write
  logic shutdown;
  assign shutdown = (state == lcdc_pkg::LCDC_ST_RUN) && !module_enable; // [R09]

  // ---------------------------------------------------------------
  // timing registers
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      frame_rate_select <= `LCDC_RST_FRM;  // [R10]
      drive_duty        <= `LCDC_RST_DUTY; // [R11]
    end else if (wr_tim1) begin
      frame_rate_select <= wdata_i[`LCDC_TIM1_FRM_LSB +: 4];
      drive_duty        <= wdata_i[`LCDC_TIM1_DTY_LSB +: 2];
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      booster_clock_select <= `LCDC_RST_BSTC; // [R12]
      inverse_line_count   <= 2'h0;
    end else if (wr_tim2) begin
      booster_clock_select <= wdata_i[`LCDC_TIM2_BST_LSB +: 2];
      inverse_line_count   <= wdata_i[`LCDC_TIM2_NL_LSB +: 2]; // [R13]
    end
  end

  // ---------------------------------------------------------------
  // power control
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      supply_mode_select      <= `LCDC_RST_EXT; // [R14]
      contrast_level          <= 4'h0;
      booster_on              <= 1'b0;
      heavy_load_mode         <= 1'b0;
      regulator_output_select <= 1'b0;
      regulator_on            <= 1'b0;
    end else begin
      if (wr_pwr) begin
        supply_mode_select      <= wdata_i[`LCDC_PWR_EXT];
        contrast_level          <= wdata_i[`LCDC_PWR_LC_LSB +: 4]; // [R15]
        booster_on              <= wdata_i[`LCDC_PWR_BST];         // [R16]
        heavy_load_mode         <= wdata_i[`LCDC_PWR_HEAVY_LOAD_MODE];        // [R17]
        regulator_output_select <= wdata_i[`LCDC_PWR_VSEL];        // [R18]
        // external supply forces the regulator off
        regulator_on <= wdata_i[`LCDC_PWR_VEN] && !wdata_i[`LCDC_PWR_EXT]; // [R20] [R21]
      end
      if (shutdown) begin
        regulator_on <= 1'b0; // [R09]
      end
    end
  end

  // display control held here so shutdown can force it
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      display_control <= 2'h0;
      display_extra   <= 3'b111;
    end else begin
      if (wr_dsp) begin
        display_control <= wdata_i[1:0];
        display_extra   <= {wdata_i[6:4]};
      end
      if (shutdown) begin
        display_control <= 2'h0; // [R09]
      end
    end
  end

  // ---------------------------------------------------------------
  // operating clock and dividers
  // ---------------------------------------------------------------
  // reserved divider codes give no clock rather than a guess
  logic       div_valid;
  logic       bypass;
  logic [2:0] div_shift;
  logic       src_tick;
  logic       run;
  logic       div_pulse;
  logic       op_tick;

  assign bypass    = (clock_source == lcdc_pkg::LCDC_SRC_LOW) ||
                     (clock_source == lcdc_pkg::LCDC_SRC_EXT);
  assign div_valid = bypass ? (clock_divider == `LCDC_DIV_BYPASS)
                            : (clock_divider <= `LCDC_DIV_MAXCODE); // [R04]
  assign div_shift = bypass ? 3'h0 : 3'(clock_divider + 3'h2);       // [R04]
  assign src_tick  = src_tick_i[clock_source];
  assign run       = module_enable && div_valid && (debug_run || !debug_i); // [R02] [R08]

  lcdc_clkdiv #(.W(7)) u_opdiv (
    .core_clk_i (core_clk_i),
    .rstn_i     (rstn_i),
    .run_i      (run),
    .tick_i     (src_tick),
    .shift_i    (div_shift),
    .pulse_o    (div_pulse)
  );
  assign op_tick = bypass ? (run && src_tick) : (run && div_pulse); // no stale tick after stop

  // booster clock: op clock over 4, 16, 32, 64
  logic [5:0] bst_cnt;
  logic [5:0] bst_mask;
  always_comb begin
    case (booster_clock_select)
      2'h0:    bst_mask = 6'h03;
      2'h1:    bst_mask = 6'h0f;
      2'h2:    bst_mask = 6'h1f;
      default: bst_mask = 6'h3f;
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (!rstn_i || !run) begin
      bst_cnt        <= 6'h00;
      boost_clk_en_o <= 1'b0;
    end else begin
      boost_clk_en_o <= op_tick && ((bst_cnt & bst_mask) == bst_mask); // [R12]
      if (op_tick) begin
        bst_cnt <= bst_cnt + 6'h01;
      end
    end
  end

  // frame switching: fixed base times frame count plus one op ticks
  logic [11:0] frm_cnt;
  logic        frame_switch;
  assign frame_switch = op_tick && (state == lcdc_pkg::LCDC_ST_RUN) &&
    (frm_cnt == 12'(FRM_BASE * (int'(frame_rate_select) + 1) - 1));

  always_ff @(posedge core_clk_i) begin
    if (!rstn_i || state != lcdc_pkg::LCDC_ST_RUN) begin
      frm_cnt <= 12'h000;
    end else if (op_tick) begin
      frm_cnt <= frame_switch ? 12'h000 : frm_cnt + 12'h001;
    end
  end

  // ---------------------------------------------------------------
  // frame interrupt
  // ---------------------------------------------------------------
  // set wins over a clear in the same cycle
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      frame_flag       <= 1'b0;
      frame_irq_enable <= 1'b0; // [R22]
    end else begin
      if (frame_switch) begin
        frame_flag <= 1'b1; // [R01]
      end else if (wr_intf && wdata_i[0]) begin
        frame_flag <= 1'b0; // [R01]
      end
      if (wr_inte) begin
        frame_irq_enable <= wdata_i[0];
      end
    end
  end
  assign irq_o = frame_flag && frame_irq_enable; // [R01] [R22]

  // ---------------------------------------------------------------
  // read port and outputs
  // ---------------------------------------------------------------
  // reserved bits read zero; unmapped index reads zero
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      rdata_o <= 16'h0000;
    end else if (rd_i) begin
      case (addr_i)
        `LCDC_IDX_CLK:  rdata_o <= {7'h00, debug_run, 1'b0, clock_divider, 2'h0, clock_source};
        `LCDC_IDX_CTL:  rdata_o <= {14'h0000, pin_discharge_enable, module_enable};
        `LCDC_IDX_TIM1: rdata_o <= {4'h0, frame_rate_select, 6'h00, drive_duty}; // [R23]
        `LCDC_IDX_TIM2: rdata_o <= {6'h00, booster_clock_select, 6'h00, inverse_line_count};
        `LCDC_IDX_PWR:  rdata_o <= {supply_mode_select, 3'h0, contrast_level, 3'h0,
                                    booster_on, 1'b0, heavy_load_mode,
                                    regulator_output_select, regulator_on};
        `LCDC_IDX_DSP:  rdata_o <= {9'h000, display_extra, 2'h0, display_control};
        `LCDC_IDX_INTF: rdata_o <= {15'h0000, frame_flag};
        `LCDC_IDX_INTE: rdata_o <= {15'h0000, frame_irq_enable};
        default:        rdata_o <= 16'h0000;
      endcase
    end
  end

  // pins low or floating only while display is off
  assign op_clk_en_o   = op_tick;
  assign pin_low_o     = (display_control == 2'h0) && pin_discharge_enable;  // [R07]
  assign pin_hiz_o     = (display_control == 2'h0) && !pin_discharge_enable; // [R07]
  assign frame_rate_o  = frame_rate_select;
  assign duty_o        = drive_duty;
  assign inv_lines_o   = inverse_line_count;
  assign display_ctl_o = display_control;
  assign ext_supply_o  = supply_mode_select;
  assign contrast_o    = contrast_level;
  assign booster_on_o  = booster_on;
  assign heavy_load_o  = heavy_load_mode;
  assign reg_out_sel_o = regulator_output_select; // [R19] software keeps zero when external
  assign reg_on_o      = regulator_on;
endmodule : lcdc_regs
`default_nettype wire

// *** bench/lcdc_regs_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "lcdc_map.svh"
// ---------------------------------------------------------------
// port checks for the register bank
// ---------------------------------------------------------------
module lcdc_regs_chk (
  // clock, reset and register port
  input wire logic        core_clk_i,
  input wire logic        rstn_i,
  input wire logic [3:0]  addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [15:0] rdata_o,
  input wire logic        debug_i,
  // panel and power outputs
  input wire logic        op_clk_en_o,
  input wire logic        pin_low_o,
  input wire logic        pin_hiz_o,
  input wire logic [3:0]  frame_rate_o,
  input wire logic [1:0]  duty_o,
  input wire logic [1:0]  display_ctl_o,
  input wire logic        ext_supply_o,
  input wire logic        booster_on_o,
  input wire logic        heavy_load_o,
  input wire logic        reg_on_o,
  input wire logic        irq_o
);
  logic en_q;
  logic ie_q;
  logic debug_run_q;
  logic dis_q;
  wire  wr_pwr = wr_i && addr_i == `LCDC_IDX_PWR;
  // shadows built from bus writes only, never from the design's state
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      en_q    <= 1'b0;
      ie_q    <= 1'b0;
      debug_run_q <= 1'b1;
      dis_q   <= 1'b0;
    end else if (wr_i) begin
      if (addr_i == `LCDC_IDX_CTL) {dis_q, en_q} <= wdata_i[1:0];
      if (addr_i == `LCDC_IDX_INTE) ie_q <= wdata_i[0];
      if (addr_i == `LCDC_IDX_CLK && !en_q) debug_run_q <= wdata_i[8];
    end
  end
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);
  a_gate_clock:
    assert property (!en_q |-> !op_clk_en_o) else $error("op tick while disabled");
  a_debug_stop:
    assert property (debug_i && !debug_run_q |-> !op_clk_en_o) else $error("op tick in debug");
  a_irq_gate:
    assert property (irq_o |-> ie_q) else $error("irq without enable");
  a_fall_off:
    assert property ($fell(en_q) && display_ctl_o != 2'h0 |-> ##[1:2]
      (display_ctl_o == 2'h0 && !reg_on_o)) else $error("display kept on");
  a_ext_clear:
    assert property (wr_pwr && wdata_i[15] |=> !reg_on_o && ext_supply_o)
    else $error("regulator left on");
  a_pwr_fields:
    assert property (wr_pwr |=> booster_on_o == $past(wdata_i[4])
      && heavy_load_o == $past(wdata_i[2])) else $error("power field wrong");
  a_reg_on:
    assert property (wr_pwr && !wdata_i[15] |=> reg_on_o == $past(wdata_i[0]))
    else $error("regulator bit wrong");
  a_timing_fields:
    assert property (wr_i && addr_i == `LCDC_IDX_TIM1 |=> frame_rate_o == $past(wdata_i[11:8])
      && duty_o == $past(wdata_i[1:0])) else $error("timing field wrong");
  a_unmapped_zero:
    assert property (rd_i && addr_i > `LCDC_IDX_INTE |=> rdata_o == 16'h0000)
    else $error("unmapped read not zero");
  a_pin_state:
    assert property (pin_low_o == (display_ctl_o == 2'h0 && dis_q)
      && pin_hiz_o == (display_ctl_o == 2'h0 && !dis_q)) else $error("pin state wrong");
  c_irq: cover property ($rose(irq_o));
  c_fall: cover property ($fell(en_q) && display_ctl_o != 2'h0);
  c_debug: cover property (debug_i && !debug_run_q && en_q);
endmodule : lcdc_regs_chk
bind lcdc_regs lcdc_regs_chk i_chk (
  .core_clk_i(core_clk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .debug_i(debug_i),
  .op_clk_en_o(op_clk_en_o), .pin_low_o(pin_low_o), .pin_hiz_o(pin_hiz_o),
  .frame_rate_o(frame_rate_o), .duty_o(duty_o), .display_ctl_o(display_ctl_o),
  .ext_supply_o(ext_supply_o), .booster_on_o(booster_on_o),
  .heavy_load_o(heavy_load_o), .reg_on_o(reg_on_o), .irq_o(irq_o)
);
`default_nettype wire

// *** bench/lcdc_panel_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// clock sources and panel-side tick counters
// ---------------------------------------------------------------
module lcdc_panel_model (
  // clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        rstn_i,
  // ticks from the block
  input  wire logic        op_tick_i,
  input  wire logic        boost_tick_i,
  // sources and counts
  output logic [3:0]       src_tick_o,
  output logic [15:0]      op_count_o,
  output logic [15:0]      boost_count_o
);
  logic [1:0] mod4;
  logic [1:0] mod3;
  // rates 1, 1/2, 1/3, 1/4 so a wrong source pick changes the count
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      mod4 <= 2'h0;
      mod3 <= 2'h0;
    end else begin
      mod4 <= mod4 + 2'h1;
      mod3 <= (mod3 == 2'h2) ? 2'h0 : mod3 + 2'h1;
    end
  end
  assign src_tick_o = {mod4 == 2'h0, mod3 == 2'h0, !mod4[0], 1'b1};
  // free-running counters; the bench only takes differences
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      op_count_o    <= 16'h0000;
      boost_count_o <= 16'h0000;
    end else begin
      op_count_o    <= op_count_o + {15'h0000, op_tick_i};
      boost_count_o <= boost_count_o + {15'h0000, boost_tick_i};
    end
  end
endmodule : lcdc_panel_model
`default_nettype wire

// *** bench/test_lcd_driver_control_regs.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "lcdc_map.svh"
module test_lcd_driver_control_regs;
  logic        core_clk_i = 1'b0;
  logic        rstn_i = 1'b0;
  logic [3:0]  addr_i = 4'h0;
  logic [15:0] wdata_i = 16'h0000;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic        debug_i = 1'b0;
  logic [15:0] rdata_o, op_cnt, boost_cnt;
  logic [3:0]  src_tick, frame_rate_o, contrast_o;
  logic [1:0]  duty_o, inv_lines_o, display_ctl_o;
  logic        op_clk_en_o, boost_clk_en_o, pin_low_o, pin_hiz_o, ext_supply_o;
  logic        booster_on_o, heavy_load_o, reg_out_sel_o, reg_on_o, irq_o;
  int          fails = 0;
  int          checks_done = 0;
  logic [15:0] rst_val [9] = '{16'h0100, 16'h0000, 16'h0703, 16'h0100, 16'h8000,
                               16'h0070, 16'h0000, 16'h0000, 16'h0000};
  // {debug, clock word} against op ticks expected in 512 cycles
  logic [16:0] ccase [9] = '{17'h0_0100, 17'h0_0150, 17'h0_0171, 17'h0_0011, 17'h0_0112,
                             17'h0_0173, 17'h0_0070, 17'h1_0000, 17'h1_0100};
  logic [15:0] cexp [9] = '{16'h0080, 16'h0004, 16'h0100, 16'h0000, 16'h0015,
                            16'h0080, 16'h0000, 16'h0000, 16'h0080};
  logic [15:0] bexp [4] = '{16'h0080, 16'h0020, 16'h0010, 16'h0008};

  always #10 core_clk_i = ~core_clk_i;

  lcdc_regs #(.FRM_BASE(2)) i_dut (
    .core_clk_i(core_clk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .src_tick_i(src_tick), .debug_i(debug_i),
    .op_clk_en_o(op_clk_en_o), .boost_clk_en_o(boost_clk_en_o), .pin_low_o(pin_low_o),
    .pin_hiz_o(pin_hiz_o), .frame_rate_o(frame_rate_o), .duty_o(duty_o),
    .inv_lines_o(inv_lines_o), .display_ctl_o(display_ctl_o), .ext_supply_o(ext_supply_o),
    .contrast_o(contrast_o), .booster_on_o(booster_on_o), .heavy_load_o(heavy_load_o),
    .reg_out_sel_o(reg_out_sel_o), .reg_on_o(reg_on_o), .irq_o(irq_o)
  );
  lcdc_panel_model i_panel (
    .core_clk_i(core_clk_i), .rstn_i(rstn_i), .op_tick_i(op_clk_en_o),
    .boost_tick_i(boost_clk_en_o), .src_tick_o(src_tick), .op_count_o(op_cnt),
    .boost_count_o(boost_cnt)
  );
  // ---------------------------------------------------------------
  // bus tasks and comparison
  // ---------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // one idle cycle after each strobe so no signal is driven twice per step
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge core_clk_i);
    wr_i <= 1'b0;
    @(posedge core_clk_i);
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge core_clk_i);
    rd_i <= 1'b0;
    #1 check(rdata_o, exp);
    @(posedge core_clk_i);
  endtask : rd
  // divider phase unknown: one tick either way, but none means none
  task automatic count_ticks(input int cyc, input logic [15:0] exp, input bit boost);
    logic [15:0] c0;
    c0 = boost ? boost_cnt : op_cnt;
    repeat (cyc) @(posedge core_clk_i);
    c0 = (boost ? boost_cnt : op_cnt) - c0;
    check((exp != 16'h0000 && c0 + 16'h0001 - exp <= 16'h0002) ? exp : c0, exp);
  endtask : count_ticks
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop
  // hang guard
  initial begin
    #1_000_000;
    fails++;
    report_and_stop();
  end
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (2) @(posedge core_clk_i);
    rstn_i <= 1'b1;
    @(posedge core_clk_i);
    for (int i = 0; i < 9; i++) rd(i[3:0], rst_val[i]);
    check({pin_hiz_o, ext_supply_o, duty_o, frame_rate_o, irq_o}, 16'h01ee);
    wr(`LCDC_IDX_CLK, 16'hffff);
    rd(`LCDC_IDX_CLK, 16'h0173);
    wr(`LCDC_IDX_TIM1, 16'hffff);
    rd(`LCDC_IDX_TIM1, 16'h0f03);
    wr(`LCDC_IDX_TIM2, 16'hffff);
    rd(`LCDC_IDX_TIM2, 16'h0303);
    check(inv_lines_o, 16'h0003);
    wr(`LCDC_IDX_PWR, 16'hfffd); // select bit kept low in external mode
    rd(`LCDC_IDX_PWR, 16'h8f14);
    check({ext_supply_o, contrast_o, booster_on_o, heavy_load_o, reg_out_sel_o, reg_on_o},
          16'h01fc);
    wr(`LCDC_IDX_PWR, 16'h0f17);
    check({ext_supply_o, contrast_o, booster_on_o, heavy_load_o, reg_out_sel_o, reg_on_o},
          16'h00ff);
    wr(`LCDC_IDX_PWR, 16'h8001);
    rd(`LCDC_IDX_PWR, 16'h8000);
    wr(4'h8, 16'hffff);
    rd(4'h8, 16'h0000);
    rd(4'hf, 16'h0000);
    wr(`LCDC_IDX_TIM2, 16'h0000);
    check(inv_lines_o, 16'h0000);
    wr(`LCDC_IDX_CTL, 16'h0002);
    check({pin_low_o, pin_hiz_o}, 16'h0002);
    wr(`LCDC_IDX_CTL, 16'h0000);
    check({pin_low_o, pin_hiz_o}, 16'h0001);
    // every source, edge divider codes, reserved codes and debug stop
    for (int i = 0; i < 9; i++) begin
      wr(`LCDC_IDX_CTL, 16'h0000);
      wr(`LCDC_IDX_CLK, ccase[i][15:0]);
      rd(`LCDC_IDX_CLK, ccase[i][15:0] & 16'h0173);
      debug_i <= ccase[i][16];
      wr(`LCDC_IDX_CTL, 16'h0001);
      count_ticks(512, cexp[i], 1'b0);
      wr(`LCDC_IDX_CLK, 16'h0000);
      rd(`LCDC_IDX_CLK, ccase[i][15:0] & 16'h0173);
    end
    debug_i <= 1'b0;
    for (int b = 0; b < 4; b++) begin
      wr(`LCDC_IDX_TIM2, {6'h00, b[1:0], 8'h00});
      count_ticks(2048, bexp[b], 1'b1);
    end
    // frames every eight cycles with the shortened frame base
    wr(`LCDC_IDX_TIM1, 16'h0003);
    wr(`LCDC_IDX_PWR, 16'h0001);
    wr(`LCDC_IDX_DSP, 16'h0071);
    #1 check({pin_low_o, pin_hiz_o}, 16'h0000);
    repeat (40) @(posedge core_clk_i);
    rd(`LCDC_IDX_INTF, 16'h0001);
    check(irq_o, 16'h0000);
    wr(`LCDC_IDX_INTE, 16'h0001);
    #1 check(irq_o, 16'h0001);
    wr(`LCDC_IDX_CTL, 16'h0000);
    @(posedge core_clk_i);
    #1 check({display_ctl_o, reg_on_o}, 16'h0000);
    rd(`LCDC_IDX_DSP, 16'h0070);
    rd(`LCDC_IDX_PWR, 16'h0000);
    wr(`LCDC_IDX_INTF, 16'h0000);
    rd(`LCDC_IDX_INTF, 16'h0001);
    wr(`LCDC_IDX_INTF, 16'h0001);
    rd(`LCDC_IDX_INTF, 16'h0000);
    check(irq_o, 16'h0000);
    report_and_stop();
  end
endmodule : test_lcd_driver_control_regs
`default_nettype wire
